//--- common/aops_pkg.sv
package aops_pkg;
  // Register indices on the serial control port.
  localparam logic [7:0] ADDR_PAT_LAT = 8'h02;
  localparam logic [7:0] ADDR_SER_GAIN = 8'h03;
  localparam logic [7:0] ADDR_CUSTOM = 8'h05;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // Register 2 fields.
  localparam int FRAME_SEL_LSB = 13;
  localparam int LOW_LAT_BIT = 12;
  localparam int MEAN_BIT = 11;
  localparam int FRAME_RND_BIT = 10;
  localparam int DATA_SEL_LSB = 7;
  localparam int ALL_RND_BIT = 6;
  localparam int WAIT_LOW_LSB = 0;
  localparam int WAIT_LOW_W = 6;
  // Register 3 fields.
  localparam int SER_LSB = 13;
  localparam int GAIN_BIT = 12;
  localparam int WAIT_HIGH_LSB = 9;
  localparam int WAIT_HIGH_W = 2;
  localparam int OFFSET_BIT = 8;
  localparam int BANK_SEL_BIT = 5;
  // Writable bits; reserved bits always read zero.
  localparam logic [15:0] REG2_MASK = 16'hffff;
  localparam logic [15:0] REG3_MASK = 16'hf720;
  // Serial frame: 8 address bits then 16 data bits.
  localparam int SPI_ADDR_W = 8;
  localparam int SPI_FRAME = 24;
  // Digital gain scaling shift: a gain of 128 is unity.
  localparam int GAIN_SHIFT = 7;
  localparam logic [22:0] PRBS_SEED = 23'h7fffff;
  localparam logic [15:0] DESKEW_WORD = 16'h5555;
  localparam logic [15:0] TOGGLE_WORD = 16'haaaa;

  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0, PAT_SYNC = 3'h1, PAT_DESKEW = 3'h2, PAT_CUSTOM = 3'h3,
    PAT_ONES = 3'h4, PAT_TOGGLE = 3'h5, PAT_ZEROS = 3'h6, PAT_RAMP = 3'h7
  } aops_pat_type;

  typedef enum logic [2:0] {
    SER_12 = 3'h0, SER_14 = 3'h1, SER_10 = 3'h3, SER_16 = 3'h4
  } aops_ser_type;

  typedef enum logic [1:0] {
    TRG_IDLE = 2'b01, TRG_WAIT = 2'b10
  } aops_trg_type;
endpackage

//--- design/aops_config.sv
`timescale 1ns/100ps
module aops_config #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_sen_n,
  input wire logic spi_sclk,
  input wire logic spi_sdata,
  output logic spi_sdout,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_a,
  input wire logic [DATA_W-1:0] sample_b,
  input wire logic [7:0] gain_value,
  input wire logic [DATA_W-1:0] offset_value,
  input wire logic trigger_start_select,
  input wire logic transmit_trigger_input,
  output logic correction_start,
  output logic lane_valid,
  output logic [DATA_W-1:0] data_lane_word,
  output logic [DATA_W-1:0] frame_clock_lane,
  output logic [4:0] serialization_factor,
  output logic high_link_bank_write_select
);
  initial begin
    if (DATA_W != 16) $error("aops_config supports DATA_W of 16 only");
  end

  localparam int SPI_FRAME_W = aops_pkg::SPI_FRAME;
  logic [15:0] reg2_r, reg2_nxt, reg3_r, reg3_nxt, custom_r, custom_nxt;
  logic [SPI_FRAME_W-1:0] sh_r, sh_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic sclk_d_r, sdout_r, sdout_nxt;
  logic [15:0] rd_word_r, rd_word_nxt;

  function automatic logic [15:0] read_reg(input logic [7:0] a, input logic [15:0] r2,
                                           input logic [15:0] r3, input logic [15:0] r5);
    if (a == aops_pkg::ADDR_PAT_LAT) read_reg = r2;
    else if (a == aops_pkg::ADDR_SER_GAIN) read_reg = r3;
    else if (a == aops_pkg::ADDR_CUSTOM) read_reg = r5;
    else read_reg = 16'h0000;
  endfunction

  // Serial port: bits are taken on sclk rising edges, MSB first, while sen_n is low.
  always_comb begin
    logic rise;
    logic [SPI_FRAME_W-1:0] shifted;
    rise = spi_sclk & ~sclk_d_r;
    shifted = {sh_r[SPI_FRAME_W-2:0], spi_sdata};
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    reg2_nxt = reg2_r;
    reg3_nxt = reg3_r;
    custom_nxt = custom_r;
    sdout_nxt = sdout_r;
    rd_word_nxt = rd_word_r;
    if (spi_sen_n) begin
      cnt_nxt = 5'h00;
    end else if (rise) begin
      sh_nxt = shifted;
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == 5'(aops_pkg::SPI_ADDR_W - 1)) begin
        rd_word_nxt = read_reg(shifted[7:0], reg2_r, reg3_r, custom_r);
        sdout_nxt = rd_word_nxt[15];
      end else if (cnt_r >= 5'(aops_pkg::SPI_ADDR_W) && cnt_r < 5'(SPI_FRAME_W - 1)) begin
        rd_word_nxt = {rd_word_r[14:0], 1'b0};
        sdout_nxt = rd_word_nxt[15];
      end
      if (cnt_r == 5'(SPI_FRAME_W - 1)) begin
        if (shifted[23:16] == aops_pkg::ADDR_PAT_LAT) reg2_nxt = shifted[15:0] & aops_pkg::REG2_MASK;
        else if (shifted[23:16] == aops_pkg::ADDR_SER_GAIN) reg3_nxt = shifted[15:0] & aops_pkg::REG3_MASK;
        else if (shifted[23:16] == aops_pkg::ADDR_CUSTOM) custom_nxt = shifted[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg2_r <= aops_pkg::RESET_VALUE;
      reg3_r <= aops_pkg::RESET_VALUE;
      custom_r <= aops_pkg::RESET_VALUE;
      sh_r <= '0;
      cnt_r <= 5'h00;
      sclk_d_r <= 1'b0;
      sdout_r <= 1'b0;
      rd_word_r <= 16'h0000;
    end else begin
      reg2_r <= reg2_nxt;
      reg3_r <= reg3_nxt;
      custom_r <= custom_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      sclk_d_r <= spi_sclk;
      sdout_r <= sdout_nxt;
      rd_word_r <= rd_word_nxt;
    end
  end

  assign spi_sdout = sdout_r;

  // Field views.
  aops_pkg::aops_pat_type frame_lane_test_select, data_lane_test_select;
  logic low_lat, two_channel_mean_on, frame_lane_random_on, all_lanes_random_on;
  logic digital_gain_on, digital_offset_subtract_on;
  logic [7:0] trigger_to_correction_wait;
  assign frame_lane_test_select = aops_pkg::aops_pat_type'(reg2_r[aops_pkg::FRAME_SEL_LSB +: 3]);
  assign data_lane_test_select = aops_pkg::aops_pat_type'(reg2_r[aops_pkg::DATA_SEL_LSB +: 3]);
  assign low_lat = reg2_r[aops_pkg::LOW_LAT_BIT];
  assign two_channel_mean_on = reg2_r[aops_pkg::MEAN_BIT];
  assign frame_lane_random_on = reg2_r[aops_pkg::FRAME_RND_BIT];
  assign all_lanes_random_on = reg2_r[aops_pkg::ALL_RND_BIT];
  assign digital_gain_on = reg3_r[aops_pkg::GAIN_BIT];
  assign digital_offset_subtract_on = reg3_r[aops_pkg::OFFSET_BIT];
  assign trigger_to_correction_wait = {reg3_r[aops_pkg::WAIT_HIGH_LSB +: aops_pkg::WAIT_HIGH_W],
                                       reg2_r[aops_pkg::WAIT_LOW_LSB +: aops_pkg::WAIT_LOW_W]};
  assign high_link_bank_write_select = reg3_r[aops_pkg::BANK_SEL_BIT];

  function automatic logic [4:0] ser_bits(input logic [2:0] code);
    case (code)
      aops_pkg::SER_14: ser_bits = 5'd14;
      aops_pkg::SER_16: ser_bits = 5'd16;
      aops_pkg::SER_10: ser_bits = 5'd10;
      default: ser_bits = 5'd12;
    endcase
  endfunction

  function automatic logic [15:0] pattern(input logic [2:0] sel, input logic [15:0] norm,
      input logic [15:0] ramp, input logic tog, input logic [15:0] cust, input logic [4:0] bits);
    logic [15:0] mask;
    mask = 16'((17'h00001 << bits) - 17'h00001);
    case (sel)
      aops_pkg::PAT_NORMAL: pattern = norm;
      aops_pkg::PAT_SYNC: pattern = mask & ~(mask >> bits[4:1]);
      aops_pkg::PAT_DESKEW: pattern = aops_pkg::DESKEW_WORD;
      aops_pkg::PAT_CUSTOM: pattern = cust;
      aops_pkg::PAT_ONES: pattern = 16'hffff;
      aops_pkg::PAT_TOGGLE: pattern = tog ? aops_pkg::TOGGLE_WORD : ~aops_pkg::TOGGLE_WORD;
      aops_pkg::PAT_ZEROS: pattern = 16'h0000;
      default: pattern = ramp;
    endcase
    pattern = pattern & mask;
  endfunction

  // Sample path: default path adds one stage of processing, low latency skips it.
  logic [15:0] proc_r, proc_nxt, data_r, data_nxt, frame_r, frame_nxt, ramp_r, ramp_nxt;
  logic [22:0] prbs_r, prbs_nxt;
  logic v1_r, v2_r, valid_r, valid_nxt, tog_r, tog_nxt;
  logic [4:0] ser_r;

  always_comb begin
    logic [16:0] sum;
    logic [23:0] prod;
    logic [15:0] s, norm, frame_norm;
    logic take;
    sum = {1'b0, sample_a} + {1'b0, sample_b};
    s = two_channel_mean_on ? sum[16:1] : sample_a;
    prod = s * gain_value;
    if (digital_gain_on) s = prod[aops_pkg::GAIN_SHIFT +: 16];
    if (digital_offset_subtract_on) s = s - offset_value;
    proc_nxt = s;
    take = low_lat ? v1_r : v2_r;
    valid_nxt = take;
    norm = low_lat ? sample_a : proc_r;
    frame_norm = pattern(aops_pkg::PAT_SYNC, 16'h0000, 16'h0000, 1'b0, 16'h0000, ser_r);
    data_nxt = data_r;
    frame_nxt = frame_r;
    ramp_nxt = ramp_r;
    tog_nxt = tog_r;
    prbs_nxt = prbs_r;
    if (take) begin
      data_nxt = pattern(data_lane_test_select, norm, ramp_r, tog_r, custom_r, ser_r);
      frame_nxt = pattern(frame_lane_test_select, frame_norm, ramp_r, tog_r, custom_r, ser_r);
      if (all_lanes_random_on) data_nxt = prbs_r[15:0];
      if (frame_lane_random_on) frame_nxt = prbs_r[15:0];
      ramp_nxt = ramp_r + 16'h0001;
      tog_nxt = ~tog_r;
      prbs_nxt = {prbs_r[21:0], prbs_r[22] ^ prbs_r[17]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_r <= 16'h0000;
      data_r <= 16'h0000;
      frame_r <= 16'h0000;
      ramp_r <= 16'h0000;
      prbs_r <= aops_pkg::PRBS_SEED;
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      valid_r <= 1'b0;
      tog_r <= 1'b0;
      ser_r <= 5'd12;
    end else begin
      proc_r <= proc_nxt;
      data_r <= data_nxt;
      frame_r <= frame_nxt;
      ramp_r <= ramp_nxt;
      prbs_r <= prbs_nxt;
      v1_r <= sample_valid;
      v2_r <= v1_r;
      valid_r <= valid_nxt;
      tog_r <= tog_nxt;
      ser_r <= ser_bits(reg3_r[aops_pkg::SER_LSB +: 3]);
    end
  end

  assign data_lane_word = data_r;
  assign frame_clock_lane = frame_r;
  assign lane_valid = valid_r;
  assign serialization_factor = ser_r;

  // Trigger to correction delay, counted in samples.
  aops_pkg::aops_trg_type trg_r, trg_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic start_r, start_nxt;

  always_comb begin
    trg_nxt = trg_r;
    wait_nxt = wait_r;
    start_nxt = 1'b0;
    case (trg_r)
      aops_pkg::TRG_IDLE: begin
        if (transmit_trigger_input && trigger_start_select) begin
          trg_nxt = aops_pkg::TRG_WAIT;
          wait_nxt = trigger_to_correction_wait;
        end
      end
      aops_pkg::TRG_WAIT: begin
        if (sample_valid) begin
          if (wait_r == 8'h00) begin
            start_nxt = 1'b1;
            trg_nxt = aops_pkg::TRG_IDLE;
          end else begin
            wait_nxt = wait_r - 8'h01;
          end
        end
      end
      default: trg_nxt = aops_pkg::TRG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_r <= aops_pkg::TRG_IDLE;
      wait_r <= 8'h00;
      start_r <= 1'b0;
    end else begin
      trg_r <= trg_nxt;
      wait_r <= wait_nxt;
      start_r <= start_nxt;
    end
  end

  assign correction_start = start_r;

  a_start_single: assert property (@(posedge clk) disable iff (!rst_n)
    correction_start |=> !correction_start) else $error("correction start longer than one cycle");
  a_trig_zero_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (trg_r == aops_pkg::TRG_IDLE && transmit_trigger_input && trigger_start_select
     && trigger_to_correction_wait == 8'h00) ##1 sample_valid |=> correction_start)
    else $error("zero wait did not start on first sample");
  a_no_trig_select: assert property (@(posedge clk) disable iff (!rst_n)
    (trg_r == aops_pkg::TRG_IDLE && !(transmit_trigger_input && trigger_start_select))
    |=> trg_r == aops_pkg::TRG_IDLE) else $error("delay ran without selected trigger");
  a_wait_order: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(trg_r == aops_pkg::TRG_WAIT) |-> wait_r == trigger_to_correction_wait)
    else $error("wait count not loaded from split field");
  a_ser_decode: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ($past(reg3_r[15:13]) == 3'h4 |-> serialization_factor == 5'd16))
    else $error("16x serialization not decoded");
  a_data_ones: assert property (@(posedge clk) disable iff (!rst_n)
    (valid_nxt && data_lane_test_select == aops_pkg::PAT_ONES && !all_lanes_random_on)
    |=> data_lane_word == 16'((17'h00001 << $past(ser_r)) - 17'h00001)) else $error("all ones wrong");
  a_frame_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (valid_nxt && frame_lane_test_select == aops_pkg::PAT_ZEROS && !frame_lane_random_on)
    |=> frame_clock_lane == 16'h0000) else $error("frame zeros wrong");
  a_frame_prbs: assert property (@(posedge clk) disable iff (!rst_n)
    (valid_nxt && frame_lane_random_on) |=> frame_clock_lane == $past(prbs_r[15:0]))
    else $error("frame lane random wrong");
  a_data_prbs: assert property (@(posedge clk) disable iff (!rst_n)
    (valid_nxt && all_lanes_random_on) |=> data_lane_word == $past(prbs_r[15:0]))
    else $error("data lane random wrong");
  a_low_latency: assert property (@(posedge clk) disable iff (!rst_n)
    low_lat && $past(low_lat) |-> lane_valid == $past(sample_valid, 2)) else $error("low latency wrong");
  a_custom_out: assert property (@(posedge clk) disable iff (!rst_n)
    (valid_nxt && data_lane_test_select == aops_pkg::PAT_CUSTOM && !all_lanes_random_on && ser_r == 5'd16)
    |=> data_lane_word == $past(custom_r)) else $error("custom pattern wrong");
endmodule

//--- verification/aops_host_model.sv
`timescale 1ns/100ps
module aops_host_model (
  input wire logic clk,
  output logic spi_sen_n,
  output logic spi_sclk,
  output logic spi_sdata,
  input wire logic spi_sdout
);
  initial begin
    spi_sen_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdata = 1'b0;
  end

  // Fewer than 24 bits aborts the frame, so the register is only read and not written.
  task automatic xfer(input logic [7:0] addr, input logic [15:0] data, input int nbits, output logic [15:0] rd);
    logic [23:0] frame;
    frame = {addr, data};
    rd = 16'h0000;
    @(posedge clk);
    spi_sen_n <= 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      spi_sdata <= frame[i];
      @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (3) @(posedge clk);
      spi_sclk <= 1'b0;
      repeat (3) @(posedge clk);
      if (i >= 1 && i <= 16) rd[i-1] = spi_sdout;
    end
    spi_sen_n <= 1'b1;
    spi_sdata <= ~frame[24-nbits];
    repeat (2) @(posedge clk);
  endtask
endmodule

//--- verification/test_aops_config.sv
`timescale 1ns/100ps
module test_aops_config;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi_sen_n, spi_sclk, spi_sdata, spi_sdout;
  logic sample_valid = 1'b0;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic [7:0] gain_value = 8'h40;
  logic [15:0] offset_value = 16'h0010;
  logic trigger_start_select = 1'b0;
  logic transmit_trigger_input = 1'b0;
  logic correction_start, lane_valid, high_link_bank_write_select;
  logic [15:0] data_lane_word, frame_clock_lane, rd, prev_d, prev_f;
  logic [4:0] serialization_factor;
  logic [2:0] sc [4] = '{3'h1, 3'h3, 3'h0, 3'h4};
  logic [4:0] sb [4] = '{5'h0e, 5'h0a, 5'h0c, 5'h10};
  logic [2:0] pc [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  logic [15:0] pw [5] = '{16'hff00, 16'h5555, 16'hc3a5, 16'hffff, 16'h0000};
  logic [15:0] fr2 [5] = '{16'h0000, 16'h0800, 16'h1800, 16'h0000, 16'h0000};
  logic [15:0] fr3 [5] = '{16'h8000, 16'h8000, 16'h8000, 16'h9000, 16'h8100};
  logic [15:0] fa [5] = '{16'h1234, 16'h0100, 16'h0100, 16'h0200, 16'h0200};
  logic [15:0] fe [5] = '{16'h1234, 16'h0200, 16'h0100, 16'h0100, 16'h01f0};
  int fl [5] = '{3, 3, 2, 3, 3};
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int hits;

  always #2.5 clk = ~clk;

  aops_config #(.DATA_W(16)) u_aops_config (.clk(clk), .rst_n(rst_n), .spi_sen_n(spi_sen_n),
    .spi_sclk(spi_sclk), .spi_sdata(spi_sdata), .spi_sdout(spi_sdout), .sample_valid(sample_valid),
    .sample_a(sample_a), .sample_b(sample_b), .gain_value(gain_value), .offset_value(offset_value),
    .trigger_start_select(trigger_start_select), .transmit_trigger_input(transmit_trigger_input),
    .correction_start(correction_start), .lane_valid(lane_valid), .data_lane_word(data_lane_word),
    .frame_clock_lane(frame_clock_lane), .serialization_factor(serialization_factor),
    .high_link_bank_write_select(high_link_bank_write_select));

  aops_host_model u_aops_host_model (.clk(clk), .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk),
    .spi_sdata(spi_sdata), .spi_sdout(spi_sdout));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_aops_host_model.xfer(a, d, 24, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    u_aops_host_model.xfer(a, 16'h0000, 23, rd);
    check(what, rd, exp);
  endtask

  // Sends one sample and checks how many cycles pass before the lanes update.
  task automatic samp(input logic [15:0] a, input logic [15:0] b, input int lat);
    int k;
    @(posedge clk);
    sample_a <= a;
    sample_b <= b;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    for (k = 1; k <= 4; k++) begin
      @(posedge clk);
      #1;
      if (lane_valid === 1'b1) break;
    end
    // Latency is counted from the edge that launched sample_valid.
    check("lane latency", 16'(k + 1), 16'(lat));
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("ser reset", {11'h000, serialization_factor}, 16'h000c);
    rdchk("reg2 reset", aops_pkg::ADDR_PAT_LAT, aops_pkg::RESET_VALUE);
    rdchk("reg3 reset", aops_pkg::ADDR_SER_GAIN, aops_pkg::RESET_VALUE);
    rdchk("unmapped", 8'h04, 16'h0000);
    samp(16'h1234, 16'h0000, 3);
    check("data 12 bit", data_lane_word, 16'h0234);
    for (int i = 0; i < 4; i++) begin
      wr(aops_pkg::ADDR_SER_GAIN, {sc[i], 13'h0000});
      check("ser factor", {11'h000, serialization_factor}, {11'h000, sb[i]});
    end
    wr(aops_pkg::ADDR_CUSTOM, 16'hc3a5);
    for (int i = 0; i < 5; i++) begin
      wr(aops_pkg::ADDR_PAT_LAT, {pc[i], 3'h0, pc[i], 7'h00});
      samp(16'h1234, 16'h0000, 3);
      check("data pattern", data_lane_word, pw[i]);
      check("frame pattern", frame_clock_lane, pw[i]);
    end
    wr(aops_pkg::ADDR_PAT_LAT, 16'he5c0);
    samp(16'h1234, 16'h0000, 3);
    prev_d = data_lane_word;
    prev_f = frame_clock_lane;
    samp(16'h1234, 16'h0000, 3);
    check("data random", {15'h0000, data_lane_word !== prev_d}, 16'h0001);
    check("frame random", {15'h0000, frame_clock_lane !== prev_f}, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(aops_pkg::ADDR_SER_GAIN, fr3[i]);
      wr(aops_pkg::ADDR_PAT_LAT, fr2[i]);
      samp(fa[i], 16'h0300, fl[i]);
      check("processed data", data_lane_word, fe[i]);
    end
    wr(aops_pkg::ADDR_SER_GAIN, 16'h9720);
    rdchk("reg3 fields", aops_pkg::ADDR_SER_GAIN, 16'h9720);
    check("bank select", {15'h0000, high_link_bank_write_select}, 16'h0001);
    wr(aops_pkg::ADDR_SER_GAIN, 16'h8200);
    wr(aops_pkg::ADDR_PAT_LAT, 16'h0002);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      trigger_start_select <= (t == 1);
      transmit_trigger_input <= 1'b1;
      @(posedge clk);
      transmit_trigger_input <= 1'b0;
      hits = 0;
      for (int n = 1; n <= 68; n++) begin
        @(posedge clk);
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        if (correction_start === 1'b1) hits = hits + n;
        @(posedge clk);
      end
      check("correction start", 16'(hits), (t == 1) ? 16'h0043 : 16'h0000);
    end
    conclude();
  end
endmodule
